// [core/lhis_defines.svh]
// constants for the display host port: bus widths, pin positions, buffer size
// assumes inclusion by the package and by the host port file
`ifndef LHIS_DEFINES_SVH
`define LHIS_DEFINES_SVH

`define LHIS_DATA_W      8
`define LHIS_FIFO_DEPTH  32
`define LHIS_SDA_BIT     7
`define LHIS_SCL_BIT     6
`define LHIS_SPI_LAST    3'h7
`define LHIS_OE_ALL      8'hff
`define LHIS_OE_NONE     8'h00

`endif

// [core/lhis_pkg.sv]
// types shared by the display host port and its receive buffer
// assumes lhis_defines.svh on the include path
`include "lhis_defines.svh"

package lhis_pkg;

    // host link flavour picked by the two straps
    typedef enum logic [1:0] {
        LHIS_MODE_6800 = 2'b00,
        LHIS_MODE_8080 = 2'b01,
        LHIS_MODE_SPI  = 2'b10
    } lhis_mode_t;

    // every pin sampled from the host, moved through the synchroniser as one word
    typedef struct packed {
        logic                     iface_type_sel;
        logic                     bus_style_sel;
        logic                     chip_sel_n;
        logic                     data_cmd_sel;
        logic                     hw_reset_n;
        logic                     read_enable_strobe;
        logic                     dir_or_write_strobe;
        logic [`LHIS_DATA_W-1:0]  d;
    } lhis_pins_t;

    // one received transfer: display data or command byte
    typedef struct packed {
        logic                     is_data;
        logic [`LHIS_DATA_W-1:0]  byte_val;
    } lhis_entry_t;

endpackage : lhis_pkg

// [core/lhis_host_port.sv]
// display host port: 6800 / 8080 parallel or 4-line serial, plus receive buffer
// assumes pins come straight from the board (asynchronous to core_clk); the
// serial clock pin also feeds serial_clk; d_in/d_out/d_oe are resolved outside
`timescale 1ns/1ps
`include "lhis_defines.svh"

module lhis_fifo
    import lhis_pkg::*;
#(
    parameter int WIDTH = `LHIS_DATA_W + 1,
    parameter int DEPTH = `LHIS_FIFO_DEPTH
) (
    input  wire logic             core_clk,   // core clock
    input  wire logic             reset,      // synchronous, active high
    input  wire logic             in_valid,   // producer offers a word
    output logic                  in_ready,   // room for a word
    input  wire logic [WIDTH-1:0] in_data,    // word to store
    output logic                  out_valid,  // a word is waiting
    input  wire logic             out_ready,  // consumer takes the word
    output logic      [WIDTH-1:0] out_data    // oldest word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end

endmodule : lhis_fifo

module lhis_host_port
    import lhis_pkg::*;
(
    input  wire logic                    core_clk,            // core clock, 100 MHz
    input  wire logic                    reset,               // synchronous, active high
    input  wire logic                    serial_clk,          // serial clock pin (line 6)
    input  wire logic                    iface_type_sel,      // strap: high parallel, low serial
    input  wire logic                    bus_style_sel,       // strap: high 6800, low 8080
    input  wire logic                    chip_sel_n,          // chip select, active low
    input  wire logic                    data_cmd_sel,        // high data, low command
    input  wire logic                    hw_reset_n,          // hardware reset, active low
    input  wire logic                    read_enable_strobe,  // 6800 enable / 8080 read_n
    input  wire logic                    dir_or_write_strobe, // 6800 direction / 8080 write_n
    input  wire logic [`LHIS_DATA_W-1:0] d_in,                // data pins as seen
    output logic      [`LHIS_DATA_W-1:0] d_out,               // data pins driven value
    output logic      [`LHIS_DATA_W-1:0] d_oe,                // high while driving a pin
    output logic                         rx_valid,            // received entry waiting
    input  wire logic                    rx_ready,            // user takes the entry
    output lhis_entry_t                  rx_entry,            // received byte and its kind
    input  wire logic [`LHIS_DATA_W-1:0] rd_data,             // byte returned on host reads
    output logic                         rd_req,              // one-cycle pulse at read start
    output logic                         rd_is_data,          // kind of the current read
    output logic                         rx_busy,             // buffer full, writes would drop
    output logic                         rx_overflow,         // sticky: a write was dropped
    output lhis_mode_t                   mode_out             // decoded link flavour
);

    // decode of the straps into a link flavour
    function automatic lhis_mode_t decode_mode(input logic iface, input logic style);
        lhis_mode_t m;
        m = LHIS_MODE_SPI;
        if (iface) begin
            m = style ? LHIS_MODE_6800 : LHIS_MODE_8080;
        end
        return m;
    endfunction : decode_mode

    // ---- serial side, on the host's clock
    logic [2:0]              bit_cnt_reg;
    logic [6:0]              shift_reg;
    logic [`LHIS_DATA_W-1:0] sbyte_reg;
    logic                    sdc_reg;
    logic                    stog_reg;

    // serial data bit count
    // chip select high ends the frame even when the host clock stops
    always_ff @(posedge serial_clk or posedge chip_sel_n) begin
        if (chip_sel_n) begin
            bit_cnt_reg <= 3'h0;
            shift_reg   <= 7'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= {shift_reg[5:0], d_in[`LHIS_SDA_BIT]};
        end
    end

    always_ff @(posedge serial_clk or negedge hw_reset_n) begin
        if (!hw_reset_n) begin
            sbyte_reg <= 8'h00;
            sdc_reg   <= 1'b0;
            stog_reg  <= 1'b0;
        end else if (!chip_sel_n && bit_cnt_reg == `LHIS_SPI_LAST) begin
            sbyte_reg <= {shift_reg, d_in[`LHIS_SDA_BIT]};
            sdc_reg   <= data_cmd_sel;
            stog_reg  <= ~stog_reg;
        end
    end

    // ---- core side
    lhis_pins_t pins_raw;
    lhis_pins_t pins_meta_reg;
    lhis_pins_t pins_sync_reg;
    lhis_pins_t pins_prev_reg;
    logic       tog_meta_reg;
    logic       tog_sync_reg;
    logic       tog_prev_reg;

    assign pins_raw = '{iface_type_sel, bus_style_sel, chip_sel_n, data_cmd_sel, hw_reset_n,
                        read_enable_strobe, dir_or_write_strobe, d_in};

    // two-stage synchronisers; the first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pins_meta_reg <= '0;
            pins_sync_reg <= '0;
        end else begin
            pins_meta_reg <= pins_raw;
            pins_sync_reg <= pins_meta_reg;
        end
    end

    // toggle chain is never reset: a core reset while the serial side holds 1 would fake a byte
    always_ff @(posedge core_clk) begin
        tog_meta_reg <= stog_reg;
        tog_sync_reg <= tog_meta_reg;
        tog_prev_reg <= tog_sync_reg;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pins_prev_reg <= '0;
        end else begin
            pins_prev_reg <= pins_sync_reg;
        end
    end

    logic        rst_all;
    lhis_mode_t  mode;
    logic        sel;
    logic        is_6800;
    logic        is_8080;
    logic        wr_evt;
    logic        spi_evt;
    logic        rd_active;
    logic        push_valid;
    logic        push_ready;
    lhis_entry_t push_entry;
    logic        rd_active_reg;
    logic [`LHIS_DATA_W-1:0] d_out_reg;
    logic [`LHIS_DATA_W-1:0] d_oe_reg;
    logic        rd_is_data_reg;
    logic        overflow_reg;

    // hardware reset pin acts like the core reset
    assign rst_all = reset || !pins_sync_reg.hw_reset_n;

    // strap decode, serial when interface strap low
    assign mode    = decode_mode(pins_sync_reg.iface_type_sel, pins_sync_reg.bus_style_sel);
    assign sel     = !pins_sync_reg.chip_sel_n;
    assign is_6800 = sel && (mode == LHIS_MODE_6800);
    assign is_8080 = sel && (mode == LHIS_MODE_8080);

    // 6800 write on enable fall with direction low
    // 8080 write on write strobe rise
    always_comb begin
        wr_evt = 1'b0;
        if (is_6800 && !pins_sync_reg.dir_or_write_strobe) begin
            wr_evt = pins_prev_reg.read_enable_strobe && !pins_sync_reg.read_enable_strobe;
        end else if (is_8080) begin
            wr_evt = !pins_prev_reg.dir_or_write_strobe && pins_sync_reg.dir_or_write_strobe;
        end
    end

    // serial bytes count only in serial mode
    assign spi_evt = (mode == LHIS_MODE_SPI) && (tog_sync_reg != tog_prev_reg);

    // direction high reads in 6800 mode
    assign rd_active = (is_6800 && pins_sync_reg.dir_or_write_strobe && pins_sync_reg.read_enable_strobe)
                    || (is_8080 && !pins_sync_reg.read_enable_strobe);

    // kind of transfer from data/command input
    always_comb begin
        push_entry.is_data  = pins_sync_reg.data_cmd_sel;
        push_entry.byte_val = pins_sync_reg.d;
        if (spi_evt) begin
            push_entry.is_data  = sdc_reg_sync_hold();
            push_entry.byte_val = sbyte_reg;
        end
    end

    // the serial byte and flag are stable for a whole byte time after the toggle
    function automatic logic sdc_reg_sync_hold();
        return sdc_reg;
    endfunction : sdc_reg_sync_hold

    assign push_valid = wr_evt || spi_evt;

    // writes cannot be stalled on the pins, so a full buffer drops and flags it
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            overflow_reg <= 1'b0;
        end else if (push_valid && !push_ready) begin
            overflow_reg <= 1'b1;
        end
    end

    // lines released unless a selected read is active
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            d_oe_reg      <= `LHIS_OE_NONE;
            rd_active_reg <= 1'b0;
        end else begin
            d_oe_reg      <= rd_active ? `LHIS_OE_ALL : `LHIS_OE_NONE;
            rd_active_reg <= rd_active;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            d_out_reg      <= 8'h00;
            rd_is_data_reg <= 1'b0;
        end else begin
            d_out_reg <= rd_data;
            if (rd_active && !rd_active_reg) begin
                rd_is_data_reg <= pins_sync_reg.data_cmd_sel;
            end
        end
    end

    lhis_fifo #(
        .WIDTH ($bits(lhis_entry_t)),
        .DEPTH (`LHIS_FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk  (core_clk),
        .reset     (rst_all),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_entry),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_entry)
    );

    assign d_out       = d_out_reg;
    assign d_oe        = d_oe_reg;
    assign rd_req      = rd_active && !rd_active_reg;
    assign rd_is_data  = rd_is_data_reg;
    assign rx_busy     = !push_ready;
    assign rx_overflow = overflow_reg;
    assign mode_out    = mode;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst_all);

    chk_mode_6800: assert property (
        pins_sync_reg.iface_type_sel && pins_sync_reg.bus_style_sel |-> mode_out == LHIS_MODE_6800)
        else $error("straps high did not select 6800");

    chk_mode_8080: assert property (
        pins_sync_reg.iface_type_sel && !pins_sync_reg.bus_style_sel |-> mode_out == LHIS_MODE_8080)
        else $error("bus strap low did not select 8080");

    chk_serial_quiet: assert property (
        !pins_sync_reg.iface_type_sel |=> d_oe == `LHIS_OE_NONE && !$rose(rd_req))
        else $error("serial mode drove the data lines");

    chk_desel_hiz: assert property (
        pins_sync_reg.chip_sel_n |=> d_oe == `LHIS_OE_NONE)
        else $error("data lines driven while deselected");

    chk_desel_nowr: assert property (
        pins_sync_reg.chip_sel_n && mode_out != LHIS_MODE_SPI |-> !push_valid)
        else $error("write taken while deselected");

    chk_read_6800: assert property (
        is_6800 && pins_sync_reg.dir_or_write_strobe && pins_sync_reg.read_enable_strobe
        |=> d_oe == `LHIS_OE_ALL)
        else $error("6800 read did not drive the bus");

    chk_write_6800: assert property (
        is_6800 && !pins_sync_reg.dir_or_write_strobe && $fell(pins_sync_reg.read_enable_strobe)
        && push_ready && !rx_valid ##0 !rx_ready
        |=> rx_valid && rx_entry.byte_val == $past(pins_sync_reg.d))
        else $error("6800 write byte not captured");

    chk_read_8080: assert property (
        is_8080 && !pins_sync_reg.read_enable_strobe |=> d_oe == `LHIS_OE_ALL)
        else $error("8080 read did not drive the bus");

    chk_write_8080: assert property (
        is_8080 && $rose(pins_sync_reg.dir_or_write_strobe) && !rx_valid && !rx_ready
        |=> rx_valid && rx_entry.is_data == $past(pins_sync_reg.data_cmd_sel))
        else $error("8080 write not captured with its kind");

    chk_reset_clear: assert property (
        @(posedge core_clk) $fell(rst_all) |-> !rx_valid && !rx_overflow && d_oe == `LHIS_OE_NONE)
        else $error("state not initialised by reset");

endmodule : lhis_host_port

// [verif/lhis_host_model.sv]
// host model for the display port: parallel 6800/8080 cycles and serial frames
// assumes one bench process calls its tasks; straps and resets belong to the bench
`timescale 1ns/1ps
`include "lhis_defines.svh"

module lhis_host_model
    import lhis_pkg::*;
(
    input  wire logic                    core_clk,            // core clock
    input  wire logic [`LHIS_DATA_W-1:0] d_out,               // device drive value
    input  wire logic [`LHIS_DATA_W-1:0] d_oe,                // device drive enable
    output logic      [`LHIS_DATA_W-1:0] d_in,                // resolved pin levels
    output logic                         serial_clk,          // serial clock, still between frames
    output logic                         chip_sel_n,          // chip select, active low
    output logic                         data_cmd_sel,        // high data, low command
    output logic                         read_enable_strobe,  // enable or read strobe
    output logic                         dir_or_write_strobe  // direction or write strobe
);
    logic [`LHIS_DATA_W-1:0] host_d;
    logic                    host_oe;
    logic [`LHIS_DATA_W-1:0] float_pat = 8'h5a;

    // a released undriven bus must not keep showing its last value
    always @(posedge core_clk) begin
        float_pat <= float_pat + 8'h35;
    end
    assign d_in = (d_oe & d_out) | (~d_oe & (host_oe ? host_d : float_pat));

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic strobe(input lhis_mode_t m, input logic wr, input logic on);
        if (m == LHIS_MODE_6800)
            read_enable_strobe = on;
        else if (wr)
            dir_or_write_strobe = ~on;
        else
            read_enable_strobe = ~on;
    endtask : strobe

    task automatic idle(input lhis_mode_t m);
        chip_sel_n          = 1'b1;
        serial_clk          = 1'b0;
        data_cmd_sel        = 1'b0;
        // strobes idle high except the 6800 enable, which idles low; unused lines tied high in serial
        read_enable_strobe  = (m != LHIS_MODE_6800);
        dir_or_write_strobe = 1'b1;
        host_d              = (m == LHIS_MODE_SPI) ? 8'hbf : 8'h00;
        host_oe             = (m == LHIS_MODE_SPI);
    endtask : idle

    // direction low for writes; data changes inside the strobe so only the right edge sees b
    task automatic par_write(input lhis_mode_t m, input logic cs_n, input logic dc, input logic [7:0] b);
        @(negedge core_clk);
        chip_sel_n          = cs_n;
        data_cmd_sel        = dc;
        host_d              = ~b;
        host_oe             = 1'b1;
        dir_or_write_strobe = (m != LHIS_MODE_6800);
        cyc(3);
        strobe(m, 1'b1, 1'b1);
        cyc(3);
        host_d = b;
        cyc(3);
        strobe(m, 1'b1, 1'b0);
        cyc(3);
        host_oe             = 1'b0;
        dir_or_write_strobe = 1'b1;
        chip_sel_n          = 1'b1;
        cyc(3);
    endtask : par_write

    task automatic par_read(input lhis_mode_t m, input logic cs_n, input logic dc,
                            output logic [7:0] got, output logic [7:0] oe_on, output logic [7:0] oe_off);
        @(negedge core_clk);
        chip_sel_n          = cs_n;
        data_cmd_sel        = dc;
        host_oe             = 1'b0;
        dir_or_write_strobe = 1'b1;
        cyc(3);
        strobe(m, 1'b0, 1'b1);
        cyc(10);
        got   = d_in;
        oe_on = d_oe;
        strobe(m, 1'b0, 1'b0);
        cyc(6);
        oe_off     = d_oe;
        chip_sel_n = 1'b1;
        cyc(2);
    endtask : par_read

    // msb first on line 7, clock on line 6, 30 ns bit period
    task automatic ser_write(input logic dc, input logic [7:0] b, input int nbits);
        @(negedge core_clk);
        chip_sel_n   = 1'b0;
        data_cmd_sel = dc;
        #7;
        for (int i = 0; i < nbits; i++) begin
            host_d[7] = b[7-i];
            #15;
            serial_clk = 1'b1;
            host_d[6]  = 1'b1;
            #15;
            serial_clk = 1'b0;
            host_d[6]  = 1'b0;
        end
        #15;
        chip_sel_n = 1'b1;
        host_d[7]  = ~host_d[7];
        cyc(6);
    endtask : ser_write

    initial begin
        idle(LHIS_MODE_6800);
    end
endmodule : lhis_host_model

// [verif/test_lcd_host_interface_select.sv]
// self-checking bench for the display host port: modes, strobes, serial, buffer, resets
// assumes the host model drives every host pin; the bench owns straps, resets and user side
`timescale 1ns/1ps
`include "lhis_defines.svh"

module test_lcd_host_interface_select
    import lhis_pkg::*;
;
    logic        core_clk, reset, hw_reset_n, iface_type_sel, bus_style_sel;
    logic        rx_ready, hold_rx, serial_clk, chip_sel_n, data_cmd_sel;
    logic        read_enable_strobe, dir_or_write_strobe, rx_valid, rd_req, rd_is_data, rx_busy, rx_overflow;
    logic [7:0]  rd_data, d_in, d_out, d_oe;
    lhis_entry_t rx_entry;
    lhis_mode_t  mode_out;
    lhis_entry_t exp_q[$];
    int          n_mismatch = 0;
    int          check_count = 0;
    int          rd_count = 0;
    int          exp_rd = 0;

    lhis_host_port lhis_host_port_inst (.core_clk(core_clk), .reset(reset), .serial_clk(serial_clk),
        .iface_type_sel(iface_type_sel), .bus_style_sel(bus_style_sel), .chip_sel_n(chip_sel_n),
        .data_cmd_sel(data_cmd_sel), .hw_reset_n(hw_reset_n), .read_enable_strobe(read_enable_strobe),
        .dir_or_write_strobe(dir_or_write_strobe), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_entry(rx_entry), .rd_data(rd_data), .rd_req(rd_req),
        .rd_is_data(rd_is_data), .rx_busy(rx_busy), .rx_overflow(rx_overflow), .mode_out(mode_out));

    lhis_host_model lhis_host_model_inst (.core_clk(core_clk), .d_out(d_out), .d_oe(d_oe), .d_in(d_in),
        .serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .data_cmd_sel(data_cmd_sel),
        .read_enable_strobe(read_enable_strobe), .dir_or_write_strobe(dir_or_write_strobe));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // the user side pops at random, except while the buffer is being filled or the hardware reset is tested
    always @(negedge core_clk) begin
        rx_ready <= hold_rx ? 1'b0 : 1'($urandom % 2);
    end

    always @(posedge core_clk) begin
        if (reset === 1'b0 && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0)
                check("rx_extra", 16'h1, 16'h0);
            else
                check("rx_entry", 16'(rx_entry), 16'(exp_q.pop_front()));
        end
        if (rd_req === 1'b1)
            rd_count++;
    end

    task automatic set_mode(input lhis_mode_t m, input logic bus);
        // let the user side take what is owed before reset clears the buffer
        for (int i = 0; i < 64 && exp_q.size() != 0; i++)
            @(negedge core_clk);
        @(negedge core_clk);
        reset = 1'b1;
        iface_type_sel = (m != LHIS_MODE_SPI);
        bus_style_sel  = bus;
        lhis_host_model_inst.idle(m);
        repeat (3) @(negedge core_clk);
        reset = 1'b0;
        repeat (6) @(negedge core_clk);
        check("mode_out", 16'(mode_out), 16'(m));
    endtask : set_mode

    task automatic wr(input lhis_mode_t m, input logic cs_n, input logic dc, input logic [7:0] b);
        if (!cs_n)
            exp_q.push_back({dc, b});
        lhis_host_model_inst.par_write(m, cs_n, dc, b);
    endtask : wr

    task automatic ser(input logic dc, input logic [7:0] b);
        exp_q.push_back({dc, b});
        lhis_host_model_inst.ser_write(dc, b, 8);
    endtask : ser

    task automatic rd(input lhis_mode_t m, input logic cs_n, input logic dc);
        logic [7:0] got;
        logic [7:0] oe_on;
        logic [7:0] oe_off;
        logic [7:0] exp_b;
        @(negedge core_clk);
        exp_b   = 8'($urandom);
        rd_data = exp_b;
        lhis_host_model_inst.par_read(m, cs_n, dc, got, oe_on, oe_off);
        check("d_oe_on", 16'(oe_on), cs_n ? 16'h0 : 16'hff);
        check("d_oe_off", 16'(oe_off), 16'h0);
        if (!cs_n) begin
            exp_rd++;
            check("rd_byte", 16'(got), 16'(exp_b));
            check("rd_is_data", 16'(rd_is_data), 16'(dc));
        end
    endtask : rd

    initial begin
        lhis_mode_t m;
        void'($urandom(32'h8a45));
        reset = 1'b1;
        hw_reset_n = 1'b1;
        iface_type_sel = 1'b1;
        bus_style_sel = 1'b1;
        rd_data = 8'h00;
        hold_rx = 1'b0;
        rx_ready = 1'b0;
        // the serial hand-over state only clears on the hardware reset pin
        @(negedge core_clk);
        hw_reset_n = 1'b0;
        repeat (7) @(negedge core_clk);
        hw_reset_n = 1'b1;
        for (int k = 0; k < 2; k++) begin
            m = k ? LHIS_MODE_8080 : LHIS_MODE_6800;
            set_mode(m, k == 0);
            for (int i = 0; i < 4; i++)
                wr(m, 1'b0, 1'(i), 8'($urandom));
            wr(m, 1'b1, 1'b1, 8'h5a);
            rd(m, 1'b0, 1'b0);
            rd(m, 1'b0, 1'b1);
            rd(m, 1'b1, 1'b0);
        end
        for (int k = 0; k < 2; k++) begin
            set_mode(LHIS_MODE_SPI, 1'(k));
            ser(1'b1, 8'($urandom));
            ser(1'b0, 8'($urandom));
            // an aborted frame leaves nothing behind
            lhis_host_model_inst.ser_write(1'b0, 8'ha5, 5);
            ser(1'b1, 8'h81);
            check("d_oe_serial", 16'(d_oe), 16'h0);
        end
        set_mode(LHIS_MODE_8080, 1'b0);
        hold_rx = 1'b1;
        for (int i = 0; i < 32; i++)
            wr(LHIS_MODE_8080, 1'b0, 1'($urandom), 8'($urandom));
        check("rx_busy", 16'(rx_busy), 16'h1);
        lhis_host_model_inst.par_write(LHIS_MODE_8080, 1'b0, 1'b1, 8'h3c);
        check("rx_overflow", 16'(rx_overflow), 16'h1);
        hold_rx = 1'b0;
        repeat (200) @(negedge core_clk);
        check("drained", 16'(rx_valid) + 16'(exp_q.size()), 16'h0);
        hold_rx = 1'b1;
        wr(LHIS_MODE_8080, 1'b0, 1'b0, 8'h11);
        hw_reset_n = 1'b0;
        repeat (5) @(negedge core_clk);
        exp_q.delete();
        hw_reset_n = 1'b1;
        repeat (6) @(negedge core_clk);
        check("hw_reset", {14'h0, rx_valid, rx_overflow}, 16'h0);
        hold_rx = 1'b0;
        wr(LHIS_MODE_8080, 1'b0, 1'b1, 8'hff);
        repeat (100) @(negedge core_clk);
        check("rx_left", 16'(exp_q.size()), 16'h0);
        check("rd_req_count", 16'(rd_count), 16'(exp_rd));
        print_verdict();
    end

    initial begin
        #100000;
        n_mismatch++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule : test_lcd_host_interface_select
